/* File: rtl/swpc_pkg.sv */
// Constants shared by the sleep, wake and poll controller
package swpc_pkg;

  // Register bus geometry
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLEEP_PERIOD = 8'h04;
  localparam logic [7:0] OFS_WAKE_HOLD = 8'h08;
  localparam logic [7:0] OFS_DEST_HIGH = 8'h0C;
  localparam logic [7:0] OFS_DEST_LOW = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_COMMAND = 8'h18;
  localparam logic [7:0] OFS_DEVICE_TYPE = 8'h1C;

  // Control and command word fields
  localparam int CTRL_SM_LSB = 0;
  localparam int CTRL_ROLE_LSB = 4;
  localparam int CTRL_API_BIT = 8;
  localparam int CTRL_CTS_BIT = 9;
  localparam int CMD_SOFT_RESET_BIT = 0;

  // Status word fields
  localparam int STAT_AWAKE_BIT = 0;
  localparam int STAT_QFULL_BIT = 1;
  localparam int STAT_RST_PEND_BIT = 2;
  localparam int STAT_PIN_BIT = 3;
  localparam int STAT_OCC_LSB = 8;

  // Sleep mode selector codes
  localparam logic [2:0] SM_NORMAL = 3'h0;
  localparam logic [2:0] SM_PIN = 3'h1;
  localparam logic [2:0] SM_CYCLIC = 3'h4;
  localparam logic [2:0] SM_CYCLIC_PIN = 3'h5;

  // Messaging role codes
  localparam logic [1:0] ROLE_NORMAL = 2'h0;
  localparam logic [1:0] ROLE_COORD = 2'h1;
  localparam logic [1:0] ROLE_POLL = 2'h2;

  // Reset values
  localparam logic [15:0] SLEEP_PERIOD_RST = 16'h0064;
  localparam logic [15:0] WAKE_HOLD_RST = 16'h0064;
  localparam logic [31:0] DEST_HIGH_RST = 32'h0000_0000;
  localparam logic [31:0] DEST_LOW_RST = 32'h0000_FFFF;

  // Report codes and bus answers
  localparam logic [7:0] STATUS_PURGED = 8'h75;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Timing
  localparam longint CLK_PERIOD_PS = 25000;
  localparam longint MS_PS = 1000000000;
  localparam int MS_CYCLES = int'(MS_PS / CLK_PERIOD_PS);
  localparam int POLL_INTERVAL_MS = 100;
  localparam int SOFT_RESET_DELAY_MS = 100;
  localparam logic [15:0] LISTEN_MS = 16'h0001;

endpackage

/* File: rtl/swpc_top.sv */
// Sleep, wake, poll and indirect queue controller with AXI4-Lite registers
// Notes on behaviour
// - Mode 0 default: never sleep
// - Mode 1: pin high, finish traffic, sleep
// - Mode 1: pin low wakes, then poll parent
// - Mode 4: sleep period, wake, send poll
// - Cyclic: no data sleeps; data holds awake
// - Awake indicator high awake, low asleep
// - Flow control: CTS low awake, high asleep
// - Mode 5: timer or pin falling edge wakes
// - Modes 4,5: data restarts sleep countdown
// - Coordinator queues unicasts until destination polls
// - Purge entries older than 2.5 sleep periods
// - API mode purge reports status 0x75
// - Queue full stalls requests; CTS follows input
// - Delivery or purge frees queue buffer
// - Broadcasts bypass queue, sent at once
// - Polling device polls every 100 ms
// - Data to destination counts as poll
// - Sleeping poller polls soon after each wake
// - Role codes: 0 normal, 1 coordinator, 2 poller
// - Soft reset acknowledged, applied 100 ms later
`timescale 1ns/100ps
module swpc_top #(
  parameter int QDEPTH = 4,
  parameter int TICK_CYC = swpc_pkg::MS_CYCLES,
  parameter logic [31:0] DEVICE_TYPE_ID = 32'h0000_5A5A
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AXI4-Lite write
  input wire logic [swpc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [swpc_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [swpc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [swpc_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host pins
  input wire logic sleep_request_pin,
  output logic awake_ind,
  output logic cts_n,
  // Link activity
  input wire logic link_busy,
  input wire logic serial_rx_event,
  input wire logic radio_rx_event,
  input wire logic serial_in_full,
  // Transmit requests
  input wire logic tx_req_valid,
  output logic tx_req_ready,
  input wire logic tx_req_broadcast,
  input wire logic [63:0] tx_req_dest,
  input wire logic [7:0] tx_req_handle,
  // Radio transmit
  output logic rf_tx_valid,
  input wire logic rf_tx_ready,
  output logic rf_tx_broadcast,
  output logic [63:0] rf_tx_dest,
  output logic [7:0] rf_tx_handle,
  // Polls
  input wire logic poll_in_valid,
  input wire logic [63:0] poll_in_src,
  output logic poll_req,
  // Reports and reset
  output logic status_valid,
  output logic [7:0] status_code,
  output logic [7:0] status_handle,
  output logic soft_reset_pulse
);
  import swpc_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYC);
  localparam int AGE_W = 19;
  localparam int OCC_W = $clog2(QDEPTH + 1);

  typedef enum logic [1:0] {PWR_AWAKE, PWR_DRAIN, PWR_ASLEEP} swpc_pwr_t;

  typedef struct packed {
    logic aw_got;
    logic [AXI_AW-1:0] awaddr;
    logic w_got;
    logic [AXI_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0] rresp;
  } swpc_bus_t;

  typedef struct packed {
    swpc_bus_t bus;
    logic [2:0] sm;
    logic [1:0] role;
    logic api;
    logic ctscfg;
    logic [15:0] sp;
    logic [15:0] wh;
    logic [31:0] dhi;
    logic [31:0] dlo;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [TICK_W-1:0] tick_cnt;
    swpc_pwr_t pstate;
    logic [15:0] sleep_tmr;
    logic [15:0] wake_tmr;
    logic poll_on_wake;
    logic [6:0] poll_tmr;
    logic poll_req;
    logic rst_pend;
    logic [6:0] rst_tmr;
    logic soft_rst;
    logic [QDEPTH-1:0] q_valid;
    logic [QDEPTH-1:0] q_deliver;
    logic [QDEPTH-1:0][63:0] q_dest;
    logic [QDEPTH-1:0][7:0] q_handle;
    logic [QDEPTH-1:0][AGE_W-1:0] q_age;
    logic tx_valid;
    logic tx_bcast;
    logic [63:0] tx_dest;
    logic [7:0] tx_handle;
    logic st_valid;
    logic [7:0] st_code;
    logic [7:0] st_handle;
    logic awake_ind;
    logic cts_n;
  } swpc_state_t;

  function automatic swpc_state_t swpc_init();
    swpc_state_t t;
    t = '0;
    t.sp = SLEEP_PERIOD_RST;
    t.wh = WAKE_HOLD_RST;
    t.dhi = DEST_HIGH_RST;
    t.dlo = DEST_LOW_RST;
    t.pstate = PWR_AWAKE;
    t.awake_ind = 1'b1;
    return t;
  endfunction

  localparam swpc_state_t ST_RST = swpc_init();

  function automatic logic [31:0] swpc_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] swpc_ctrl_word(input swpc_state_t t);
    logic [31:0] r;
    r = '0;
    r[CTRL_SM_LSB +: 3] = t.sm;
    r[CTRL_ROLE_LSB +: 2] = t.role;
    r[CTRL_API_BIT] = t.api;
    r[CTRL_CTS_BIT] = t.ctscfg;
    return r;
  endfunction

  swpc_state_t s_ff;
  swpc_state_t nxt_s;
  swpc_bus_t bus_keep;
  logic tick;
  logic pin;
  logic pin_fall;
  logic awake;
  logic cyc;
  logic data_ev;
  logic wake;
  logic slot_free;
  logic queued;
  logic have_free;
  logic any_deliver;
  logic any_purge;
  logic [31:0] wv;
  logic [31:0] stat_word;
  logic [OCC_W-1:0] occ;
  int free_idx;
  int dlv_idx;
  int prg_idx;

  //////////////////////////////////////////////////////////////////////////////
  // Handshake outputs
  assign s_axi_awready = !s_ff.bus.aw_got;
  assign s_axi_wready = !s_ff.bus.w_got;
  assign s_axi_arready = !s_ff.bus.rvalid;
  assign queued = (s_ff.role == ROLE_COORD) && !tx_req_broadcast;
  assign slot_free = !s_ff.tx_valid || rf_tx_ready;
  assign tx_req_ready = queued ? have_free : (slot_free && !any_deliver);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_s = s_ff;
    bus_keep = '0;
    wv = '0;
    wake = 1'b0;
    nxt_s.poll_req = 1'b0;
    nxt_s.soft_rst = 1'b0;
    nxt_s.st_valid = 1'b0;
    tick = (s_ff.tick_cnt == TICK_W'(TICK_CYC - 1));
    nxt_s.tick_cnt = tick ? '0 : s_ff.tick_cnt + 1'b1;
    nxt_s.pin_s1 = sleep_request_pin;
    nxt_s.pin_s2 = s_ff.pin_s1;
    nxt_s.pin_prev = s_ff.pin_s2;
    pin = s_ff.pin_s2;
    pin_fall = s_ff.pin_prev && !s_ff.pin_s2;
    awake = (s_ff.pstate != PWR_ASLEEP);
    cyc = (s_ff.sm == SM_CYCLIC) || (s_ff.sm == SM_CYCLIC_PIN);
    data_ev = serial_rx_event || radio_rx_event;

    // Queue scan
    have_free = 1'b0;
    any_deliver = 1'b0;
    any_purge = 1'b0;
    free_idx = 0;
    dlv_idx = 0;
    prg_idx = 0;
    occ = '0;
    for (int i = QDEPTH - 1; i >= 0; i--) begin
      if (!s_ff.q_valid[i]) begin
        have_free = 1'b1;
        free_idx = i;
      end else begin
        occ = occ + 1'b1;
      end
      if (s_ff.q_valid[i] && s_ff.q_deliver[i]) begin
        any_deliver = 1'b1;
        dlv_idx = i;
      end
      if (s_ff.q_valid[i] && !s_ff.q_deliver[i] &&
          ({s_ff.q_age[i], 1'b0} > ({2'b00, s_ff.sp, 2'b00} + {4'h0, s_ff.sp}))) begin
        any_purge = 1'b1;
        prg_idx = i;
      end
    end

    // Register bus
    if (s_axi_awvalid && !s_ff.bus.aw_got) begin
      nxt_s.bus.aw_got = 1'b1;
      nxt_s.bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_ff.bus.w_got) begin
      nxt_s.bus.w_got = 1'b1;
      nxt_s.bus.wdata = s_axi_wdata;
      nxt_s.bus.wstrb = s_axi_wstrb;
    end
    if (s_ff.bus.bvalid && s_axi_bready) begin
      nxt_s.bus.bvalid = 1'b0;
    end
    if (s_ff.bus.aw_got && s_ff.bus.w_got && !s_ff.bus.bvalid) begin
      nxt_s.bus.aw_got = 1'b0;
      nxt_s.bus.w_got = 1'b0;
      nxt_s.bus.bvalid = 1'b1;
      nxt_s.bus.bresp = RESP_OKAY;
      case (s_ff.bus.awaddr)
        OFS_CTRL: begin
          wv = swpc_merge(swpc_ctrl_word(s_ff), s_ff.bus.wdata, s_ff.bus.wstrb);
          nxt_s.sm = wv[CTRL_SM_LSB +: 3];
          nxt_s.role = wv[CTRL_ROLE_LSB +: 2];
          nxt_s.api = wv[CTRL_API_BIT];
          nxt_s.ctscfg = wv[CTRL_CTS_BIT];
        end
        OFS_SLEEP_PERIOD: begin
          wv = swpc_merge({16'h0000, s_ff.sp}, s_ff.bus.wdata, s_ff.bus.wstrb);
          nxt_s.sp = wv[15:0];
        end
        OFS_WAKE_HOLD: begin
          wv = swpc_merge({16'h0000, s_ff.wh}, s_ff.bus.wdata, s_ff.bus.wstrb);
          nxt_s.wh = wv[15:0];
        end
        OFS_DEST_HIGH: nxt_s.dhi = swpc_merge(s_ff.dhi, s_ff.bus.wdata, s_ff.bus.wstrb);
        OFS_DEST_LOW: nxt_s.dlo = swpc_merge(s_ff.dlo, s_ff.bus.wdata, s_ff.bus.wstrb);
        OFS_COMMAND: begin
          if (s_ff.bus.wstrb[0] && s_ff.bus.wdata[CMD_SOFT_RESET_BIT] && !s_ff.rst_pend) begin
            nxt_s.rst_pend = 1'b1;
            nxt_s.rst_tmr = '0;
          end
        end
        OFS_STATUS, OFS_DEVICE_TYPE: nxt_s.bus.bresp = RESP_OKAY;
        default: nxt_s.bus.bresp = RESP_SLVERR;
      endcase
    end
    stat_word = '0;
    stat_word[STAT_AWAKE_BIT] = awake;
    stat_word[STAT_QFULL_BIT] = !have_free;
    stat_word[STAT_RST_PEND_BIT] = s_ff.rst_pend;
    stat_word[STAT_PIN_BIT] = pin;
    stat_word[STAT_OCC_LSB +: OCC_W] = occ;
    if (s_ff.bus.rvalid && s_axi_rready) begin
      nxt_s.bus.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_ff.bus.rvalid) begin
      nxt_s.bus.rvalid = 1'b1;
      nxt_s.bus.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL: nxt_s.bus.rdata = swpc_ctrl_word(s_ff);
        OFS_SLEEP_PERIOD: nxt_s.bus.rdata = {16'h0000, s_ff.sp};
        OFS_WAKE_HOLD: nxt_s.bus.rdata = {16'h0000, s_ff.wh};
        OFS_DEST_HIGH: nxt_s.bus.rdata = s_ff.dhi;
        OFS_DEST_LOW: nxt_s.bus.rdata = s_ff.dlo;
        OFS_STATUS: nxt_s.bus.rdata = stat_word;
        OFS_COMMAND: nxt_s.bus.rdata = '0;
        OFS_DEVICE_TYPE: nxt_s.bus.rdata = DEVICE_TYPE_ID;
        default: begin
          nxt_s.bus.rdata = '0;
          nxt_s.bus.rresp = RESP_SLVERR;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // Power state
    case (s_ff.pstate)
      PWR_AWAKE: begin
        if (tick && (s_ff.wake_tmr != '0)) begin
          nxt_s.wake_tmr = s_ff.wake_tmr - 1'b1;
        end
        if (data_ev) begin
          nxt_s.wake_tmr = s_ff.wh;
        end
        if ((s_ff.sm == SM_PIN) && pin) begin
          nxt_s.pstate = PWR_DRAIN;
        end else if (cyc && (s_ff.wake_tmr == '0) && !s_ff.poll_on_wake && !data_ev) begin
          nxt_s.pstate = PWR_DRAIN;
        end
      end
      PWR_DRAIN: begin
        if ((s_ff.sm == SM_NORMAL) || ((s_ff.sm == SM_PIN) && !pin) || (!cyc && (s_ff.sm != SM_PIN))) begin
          nxt_s.pstate = PWR_AWAKE;
        end else if (cyc && data_ev) begin
          nxt_s.wake_tmr = s_ff.wh;
          nxt_s.pstate = PWR_AWAKE;
        end else if (!link_busy) begin
          nxt_s.pstate = PWR_ASLEEP;
          nxt_s.sleep_tmr = s_ff.sp;
        end
      end
      PWR_ASLEEP: begin
        if (tick && (s_ff.sleep_tmr != '0)) begin
          nxt_s.sleep_tmr = s_ff.sleep_tmr - 1'b1;
        end
        case (s_ff.sm)
          SM_PIN: wake = !pin;
          SM_CYCLIC: wake = (s_ff.sleep_tmr == '0);
          SM_CYCLIC_PIN: wake = (s_ff.sleep_tmr == '0) || pin_fall;
          default: wake = 1'b1;
        endcase
        if (wake) begin
          nxt_s.pstate = PWR_AWAKE;
          nxt_s.wake_tmr = LISTEN_MS;
          nxt_s.poll_on_wake = (s_ff.sm != SM_NORMAL);
          nxt_s.poll_tmr = '0;
        end
      end
      default: nxt_s.pstate = PWR_AWAKE;
    endcase

    //////////////////////////////////////////////////////////////////////////////
    // Polling
    if (awake && s_ff.poll_on_wake) begin
      nxt_s.poll_req = 1'b1;
      nxt_s.poll_on_wake = 1'b0;
      nxt_s.poll_tmr = '0;
    end else if (awake && ((s_ff.role == ROLE_POLL) || cyc) && tick) begin
      if (s_ff.poll_tmr == 7'(POLL_INTERVAL_MS - 1)) begin
        nxt_s.poll_req = 1'b1;
        nxt_s.poll_tmr = '0;
      end else begin
        nxt_s.poll_tmr = s_ff.poll_tmr + 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Queue and transmit slot
    if (s_ff.tx_valid && rf_tx_ready) begin
      nxt_s.tx_valid = 1'b0;
    end
    for (int i = 0; i < QDEPTH; i++) begin
      if (tick && s_ff.q_valid[i]) begin
        nxt_s.q_age[i] = s_ff.q_age[i] + 1'b1;
      end
      if (poll_in_valid && s_ff.q_valid[i] && (s_ff.q_dest[i] == poll_in_src)) begin
        nxt_s.q_deliver[i] = 1'b1;
      end
    end
    if (any_purge) begin
      nxt_s.q_valid[prg_idx] = 1'b0;
      nxt_s.q_deliver[prg_idx] = 1'b0;
      if (s_ff.api) begin
        nxt_s.st_valid = 1'b1;
        nxt_s.st_code = STATUS_PURGED;
        nxt_s.st_handle = s_ff.q_handle[prg_idx];
      end
    end
    if (slot_free && any_deliver) begin
      nxt_s.tx_valid = 1'b1;
      nxt_s.tx_bcast = 1'b0;
      nxt_s.tx_dest = s_ff.q_dest[dlv_idx];
      nxt_s.tx_handle = s_ff.q_handle[dlv_idx];
      nxt_s.q_valid[dlv_idx] = 1'b0;
      nxt_s.q_deliver[dlv_idx] = 1'b0;
    end
    if (tx_req_valid && tx_req_ready) begin
      if (queued) begin
        nxt_s.q_valid[free_idx] = 1'b1;
        nxt_s.q_deliver[free_idx] = 1'b0;
        nxt_s.q_age[free_idx] = '0;
        nxt_s.q_dest[free_idx] = tx_req_dest;
        nxt_s.q_handle[free_idx] = tx_req_handle;
      end else begin
        nxt_s.tx_valid = 1'b1;
        nxt_s.tx_bcast = tx_req_broadcast;
        nxt_s.tx_dest = tx_req_dest;
        nxt_s.tx_handle = tx_req_handle;
        if ((s_ff.role == ROLE_POLL) && !tx_req_broadcast && (tx_req_dest == {s_ff.dhi, s_ff.dlo})) begin
          nxt_s.poll_tmr = '0;
        end
      end
    end

    nxt_s.awake_ind = (nxt_s.pstate != PWR_ASLEEP);
    nxt_s.cts_n = s_ff.ctscfg && !(nxt_s.awake_ind && !serial_in_full);

    //////////////////////////////////////////////////////////////////////////////
    // Deferred soft reset
    if (s_ff.rst_pend && tick) begin
      nxt_s.rst_tmr = s_ff.rst_tmr + 1'b1;
      if (s_ff.rst_tmr == 7'(SOFT_RESET_DELAY_MS - 1)) begin
        bus_keep = nxt_s.bus;
        nxt_s = ST_RST;
        nxt_s.bus = bus_keep;
        nxt_s.soft_rst = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_bvalid = s_ff.bus.bvalid;
  assign s_axi_bresp = s_ff.bus.bresp;
  assign s_axi_rvalid = s_ff.bus.rvalid;
  assign s_axi_rdata = s_ff.bus.rdata;
  assign s_axi_rresp = s_ff.bus.rresp;
  assign awake_ind = s_ff.awake_ind;
  assign cts_n = s_ff.cts_n;
  assign rf_tx_valid = s_ff.tx_valid;
  assign rf_tx_broadcast = s_ff.tx_bcast;
  assign rf_tx_dest = s_ff.tx_dest;
  assign rf_tx_handle = s_ff.tx_handle;
  assign poll_req = s_ff.poll_req;
  assign status_valid = s_ff.st_valid;
  assign status_code = s_ff.st_code;
  assign status_handle = s_ff.st_handle;
  assign soft_reset_pulse = s_ff.soft_rst;

endmodule

/* File: verif/swpc_chk.sv */
// Port checker for the sleep, wake and poll controller
`timescale 1ns/100ps
module swpc_chk
  import swpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys, reset_n,
  // Bus read
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [swpc_pkg::AXI_DW-1:0] s_axi_rdata,
  // Transmit paths
  input wire logic tx_req_valid, tx_req_ready, tx_req_broadcast,
  input wire logic rf_tx_valid, rf_tx_ready, rf_tx_broadcast,
  input wire logic [63:0] rf_tx_dest,
  // Power and reports
  input wire logic awake_ind, poll_req, link_busy, status_valid, soft_reset_pulse,
  input wire logic [7:0] status_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bcast_direct: assert property (
    tx_req_valid && tx_req_ready && tx_req_broadcast |=> rf_tx_valid && rf_tx_broadcast) else $error("bcast held");
  a_tx_hold: assert property (rf_tx_valid && !rf_tx_ready |=> rf_tx_valid && $stable(rf_tx_dest))
    else $error("tx dropped");
  a_sleep_idle: assert property ($fell(awake_ind) |-> !$past(link_busy)) else $error("slept busy");
  a_wake_poll: assert property (
    $rose(awake_ind) && !soft_reset_pulse |-> ##[0:2] poll_req) else $error("no wake poll");
  a_purge_code: assert property (status_valid |-> status_code == STATUS_PURGED) else $error("bad code");
  a_reset_awake: assert property (soft_reset_pulse |-> ##[0:2] awake_ind) else $error("not awake");
endmodule

/* File: verif/swpc_host.sv */
// Host and radio partner: sleep pin and transmit acceptance
`timescale 1ns/100ps
module swpc_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bench commands
  input wire logic want_sleep,
  input wire logic slow,
  // Pins toward the block
  output logic sleep_request_pin,
  output logic rf_tx_ready
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 2'h0;
      sleep_request_pin <= 1'b0;
      rf_tx_ready <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      sleep_request_pin <= want_sleep;
      rf_tx_ready <= !slow || (cnt_ff == 2'h3);
    end
  end
endmodule

/* File: verif/tb_sleep_wake_poll_controller.sv */
// Self-checking bench for the sleep, wake and poll controller
`timescale 1ns/100ps
module tb_sleep_wake_poll_controller;
  import swpc_pkg::*;
  typedef struct {int k; logic [79:0] v;} swpc_exp_t;
  logic clk_sys = 1'b0, reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic link_busy = 1'b0, serial_rx_event = 1'b0, radio_rx_event = 1'b0, serial_in_full = 1'b0;
  logic tx_req_valid = 1'b0, tx_req_broadcast = 1'b0, poll_in_valid = 1'b0, want_sleep = 1'b0, slow = 1'b0;
  logic [63:0] tx_req_dest = 64'h0, poll_in_src = 64'h0, rf_tx_dest;
  logic [7:0] tx_req_handle = 8'h00, rf_tx_handle, status_code, status_handle, h;
  logic tx_req_ready, rf_tx_valid, rf_tx_ready, rf_tx_broadcast, poll_req, status_valid, soft_reset_pulse;
  logic sleep_request_pin, awake_ind, cts_n;
  logic [7:0] hs [4];
  logic [31:0] rs = 32'h0000_003A;
  int bad_count = 0, compares = 0, polls = 0, n, p;
  swpc_exp_t exp_q[$];
  // Device type value is arbitrary
  swpc_top #(.TICK_CYC(20), .DEVICE_TYPE_ID(32'h0000_3C3C)) dut_u (.*);
  swpc_host host_u (.*);
  always #12.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic aw(input logic l, input int m);
    for (n = 0; n < m && awake_ind !== l; n++) cyc(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    exp_q.push_back('{2, {78'h0, er}});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk_sys);
    exp_q.push_back('{1, {46'h0, e}});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic tx(input logic b, input logic [63:0] d, input logic dir, output logic [7:0] hh);
    hh = 8'(xs());
    @(posedge clk_sys);
    if (dir) exp_q.push_back('{3, {7'h0, b, hh, d}});
    tx_req_broadcast <= b;
    tx_req_dest <= d;
    tx_req_handle <= hh;
    tx_req_valid <= 1'b1;
    do @(posedge clk_sys); while (tx_req_ready !== 1'b1);
    tx_req_valid <= 1'b0;
  endtask
  task automatic pop(input int k, input logic [79:0] g);
    swpc_exp_t e;
    e = exp_q.size() ? exp_q.pop_front() : swpc_exp_t'{0, 80'h0};
    chk("result kind", 80'(k), 80'(e.k));
    chk("result value", e.v, g);
  endtask
  always @(posedge clk_sys) begin
    if (poll_req === 1'b1) polls++;
    if (s_axi_rvalid && s_axi_rready) pop(1, {46'h0, s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) pop(2, {78'h0, s_axi_bresp});
    if (rf_tx_valid && rf_tx_ready) pop(3, {7'h0, rf_tx_broadcast, rf_tx_handle, rf_tx_dest});
    if (status_valid) pop(4, {64'h0, status_code, status_handle});
  end
  initial begin
    #(25 * 40000);
    bad_count++;
    end_of_test();
  end
  initial begin
    cyc(2);
    reset_n <= 1'b1;
    rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0000});
    rd(OFS_SLEEP_PERIOD, {RESP_OKAY, 16'h0000, SLEEP_PERIOD_RST});
    rd(OFS_WAKE_HOLD, {RESP_OKAY, 16'h0000, WAKE_HOLD_RST});
    rd(OFS_DEST_HIGH, {RESP_OKAY, DEST_HIGH_RST});
    rd(OFS_DEST_LOW, {RESP_OKAY, DEST_LOW_RST});
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0001});
    rd(OFS_DEVICE_TYPE, {RESP_OKAY, 32'h0000_3C3C});
    rd(8'h20, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("Test done: registers");
    wr(OFS_CTRL, 32'h0000_0201, RESP_OKAY);
    link_busy <= 1'b1;
    want_sleep <= 1'b1;
    cyc(20);
    chk("awake busy", 1'b1, awake_ind);
    link_busy <= 1'b0;
    aw(1'b0, 20);
    chk("asleep", 1'b0, awake_ind);
    chk("cts asleep", 1'b1, cts_n);
    p = polls;
    want_sleep <= 1'b0;
    aw(1'b1, 20);
    cyc(3);
    chk("cts awake", 1'b0, cts_n);
    chk("pin wake poll", 1'b1, polls > p);
    $display("Test done: pin sleep");
    wr(OFS_SLEEP_PERIOD, 32'h0000_0003, RESP_OKAY);
    wr(OFS_WAKE_HOLD, 32'h0000_0002, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0004, RESP_OKAY);
    aw(1'b0, 100);
    p = polls;
    aw(1'b1, 120);
    chk("sleep length", 1'b1, n >= 39 && n <= 82);
    cyc(3);
    chk("cyclic poll", 1'b1, polls > p);
    aw(1'b0, 60);
    chk("short wake", 1'b1, n <= 45);
    aw(1'b1, 100);
    for (p = 0; p < 6; p++) begin
      {serial_rx_event, radio_rx_event} <= p[0] ? 2'b01 : 2'b10;
      cyc(1);
      {serial_rx_event, radio_rx_event} <= 2'b00;
      chk("held awake", 1'b1, awake_ind);
      if (p < 5) cyc(19);
    end
    aw(1'b0, 100);
    chk("hold expiry", 1'b1, n >= 20 && awake_ind === 1'b0);
    $display("Test done: cyclic sleep");
    wr(OFS_SLEEP_PERIOD, 32'h0000_0032, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0005, RESP_OKAY);
    aw(1'b1, 1200);
    aw(1'b0, 100);
    want_sleep <= 1'b1;
    cyc(20);
    chk("high pin ignored", 1'b0, awake_ind);
    want_sleep <= 1'b0;
    aw(1'b1, 20);
    chk("pin early wake", 1'b1, awake_ind);
    serial_rx_event <= 1'b1;
    cyc(1);
    serial_rx_event <= 1'b0;
    want_sleep <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    cyc(300);
    chk("mode 0 awake", 1'b1, awake_ind);
    want_sleep <= 1'b0;
    $display("Test done: pin wake and normal");
    wr(OFS_SLEEP_PERIOD, 32'h0000_0002, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0310, RESP_OKAY);
    slow <= 1'b1;
    serial_in_full <= 1'b1;
    cyc(3);
    chk("cts full", 1'b1, cts_n);
    serial_in_full <= 1'b0;
    tx(1'b1, {32'h0000_0000, xs()}, 1'b1, h);
    tx(1'b0, 64'h0000_0000_0000_00A1, 1'b0, h);
    cyc(20);
    chk("unicast held", 1'b0, rf_tx_valid);
    exp_q.push_back('{3, {8'h00, h, 64'h0000_0000_0000_00A1}});
    poll_in_src <= 64'h0000_0000_0000_00A1;
    poll_in_valid <= 1'b1;
    cyc(1);
    poll_in_valid <= 1'b0;
    cyc(10);
    chk("poll delivery", 1'b1, exp_q.size() == 0);
    for (p = 0; p < 4; p++) tx(1'b0, 64'h0000_0000_0000_00B2, 1'b0, hs[p]);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0403});
    for (p = 0; p < 4; p++) exp_q.push_back('{4, {64'h0, STATUS_PURGED, hs[p]}});
    tx(1'b0, 64'h0000_0000_0000_00B2, 1'b0, h);
    exp_q.push_back('{4, {64'h0, STATUS_PURGED, h}});
    for (n = 1; n < 200 && exp_q.size() > 1; n++) cyc(1);
    cyc(1);
    while (n < 200 && status_valid !== 1'b1) begin
      n++;
      cyc(1);
    end
    chk("purge age", 1'b1, n >= 100 && n <= 145);
    cyc(3);
    chk("all purged", 1'b1, exp_q.size() == 0);
    slow <= 1'b0;
    $display("Test done: indirect queue");
    wr(OFS_CTRL, 32'h0000_0020, RESP_OKAY);
    p = polls;
    for (n = 0; n < 2100 && polls == p; n++) cyc(1);
    p = polls;
    for (n = 0; n < 2100 && polls == p; n++) cyc(1);
    chk("poll gap", 1'b1, n >= 1980 && n <= 2002);
    cyc(1000);
    tx(1'b0, {DEST_HIGH_RST, DEST_LOW_RST}, 1'b1, h);
    p = polls;
    for (n = 0; n < 2100 && polls == p; n++) cyc(1);
    chk("data as poll", 1'b1, n >= 1900 && polls != p);
    $display("Test done: polling");
    wr(OFS_COMMAND, 32'h0000_0001, RESP_OKAY);
    for (n = 0; n < 2200 && soft_reset_pulse !== 1'b1; n++) cyc(1);
    chk("reset delay", 1'b1, n >= 1975 && n <= 2045);
    rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0000});
    $display("Test done: soft reset");
    end_of_test();
  end
endmodule
bind swpc_top swpc_chk chk_u (.*);
